// >>> rtl/sfsc_pkg.sv
// What this block does
// - Strap selects one of three slave addresses
// - Command 00h: target count, resets FFh
// - Command 01h: measured tach count, read-only
// - Command 02h: fail bit1, active-low regulation bit0
// - Command 03h: open-loop drive level, resets 00h
// - Bits 7/6 enable fail and regulation flags
// - Bit 5 selects PWM or linear drive
// - Bit 4 selects closed loop; resets 10h
// - Bits 3:2 divide tach clock 1/2/4/8
// - Bit 1 inverts PWM duty
// - Bit 0 selects two or four pulses
// - Secondary bit 4 masks the alert output
// - Secondary bits 3:2 pick measuring window
// - Secondary bits 1:0 pick start-up code
// - Access by Write Byte and Read Byte
// - Fail flag after 0.7 s without transitions
// - Alert latched low until alert-response read
package sfsc_pkg;

  // Command codes
  localparam logic [7:0] SFSC_CMD_TARGET = 8'h00;
  localparam logic [7:0] SFSC_CMD_MEASURED = 8'h01;
  localparam logic [7:0] SFSC_CMD_FLAGS = 8'h02;
  localparam logic [7:0] SFSC_CMD_LEVEL = 8'h03;
  localparam logic [7:0] SFSC_CMD_CFG1 = 8'h04;
  localparam logic [7:0] SFSC_CMD_CFG2 = 8'h05;

  // Slave addresses for strap high, floating, low; alert response address
  localparam logic [6:0] SFSC_ADDR_STRAP_HIGH = 7'h3E;
  localparam logic [6:0] SFSC_ADDR_STRAP_FLOAT = 7'h48;
  localparam logic [6:0] SFSC_ADDR_STRAP_LOW = 7'h49;
  localparam logic [6:0] SFSC_ADDR_ALERT_RESP = 7'h0C;

  // Reset values
  localparam logic [7:0] SFSC_TARGET_RST = 8'hFF;
  localparam logic [7:0] SFSC_MEASURED_RST = 8'hFF;
  localparam logic [1:0] SFSC_FLAGS_RST = 2'h1;
  localparam logic [7:0] SFSC_LEVEL_RST = 8'h00;
  localparam logic [7:0] SFSC_CFG1_RST = 8'h10;
  localparam logic [4:0] SFSC_CFG2_RST = 5'h01;

  // Field positions
  localparam int SFSC_CFG1_STALL_EN = 7;
  localparam int SFSC_CFG1_REG_EN = 6;
  localparam int SFSC_CFG1_PWM_SEL = 5;
  localparam int SFSC_CFG1_CLOSED = 4;
  localparam int SFSC_CFG1_PRESC_HI = 3;
  localparam int SFSC_CFG1_PRESC_LO = 2;
  localparam int SFSC_CFG1_INVERT = 1;
  localparam int SFSC_CFG1_PPR = 0;
  localparam int SFSC_CFG2_MASK = 4;
  localparam int SFSC_CFG2_WIN_HI = 3;
  localparam int SFSC_CFG2_WIN_LO = 2;
  localparam int SFSC_CFG2_START_HI = 1;
  localparam int SFSC_CFG2_START_LO = 0;
  localparam int SFSC_FLAG_FAIL = 1;
  localparam int SFSC_FLAG_OOC_N = 0;
  localparam int SFSC_STARTUP_SHIFT = 5;

  // Timing: clock period and the two supervision times
  localparam longint unsigned SFSC_CLK_PERIOD_NS = 4;
  localparam longint unsigned SFSC_STALL_TIME_MS = 700;
  localparam longint unsigned SFSC_OOC_TIME_S = 6;
  localparam longint unsigned SFSC_STALL_CYCLES = SFSC_STALL_TIME_MS * 1000000 / SFSC_CLK_PERIOD_NS;
  localparam longint unsigned SFSC_OOC_CYCLES = SFSC_OOC_TIME_S * 1000000000 / SFSC_CLK_PERIOD_NS;

  // Bus engine states
  typedef enum logic [2:0] {
    SFSC_BUS_IDLE = 3'b000,
    SFSC_BUS_ADDR = 3'b001,
    SFSC_BUS_CMD = 3'b010,
    SFSC_BUS_WDATA = 3'b011,
    SFSC_BUS_RDATA = 3'b100,
    SFSC_BUS_IGNORE = 3'b101
  } sfsc_bus_state_t;

  // Decoded configuration
  typedef struct packed {
    logic stall_en;
    logic reg_en;
    logic pwm_sel;
    logic closed;
    logic [1:0] prescale;
    logic invert;
    logic ppr4;
    logic alert_mask;
    logic [1:0] window;
    logic [1:0] startup;
  } sfsc_cfg_t;

  // Measurement result from the tach meter
  typedef struct packed {
    logic valid;
    logic transition;
    logic [7:0] count;
  } sfsc_tach_t;

  // Tach meter state
  typedef struct packed {
    logic tach_q;
    logic [2:0] presc;
    logic [7:0] ticks;
    logic [3:0] edges;
    logic [7:0] count;
    logic valid;
    logic transition;
  } sfsc_tach_state_t;

  // Controller state
  typedef struct packed {
    sfsc_bus_state_t bus;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic scl_q;
    logic sda_q;
    logic sda_drive;
    logic ara;
    logic [7:0] cmd;
    logic [6:0] own_addr;
    logic strap_done;
    logic [7:0] target;
    logic [7:0] level;
    logic [7:0] cfg1;
    logic [4:0] cfg2;
    logic fail;
    logic ooc_n;
    logic alert;
    logic [31:0] stall_cnt;
    logic [31:0] ooc_cnt;
    logic [8:0] drive;
    logic [8:0] pwm_cnt;
    logic [8:0] dac;
    logic pwm_q;
  } sfsc_top_state_t;

  // Split the two configuration bytes into named fields
  function automatic sfsc_cfg_t sfsc_decode_cfg(input logic [7:0] c1, input logic [4:0] c2);
    sfsc_cfg_t c;
    c.stall_en = c1[SFSC_CFG1_STALL_EN];
    c.reg_en = c1[SFSC_CFG1_REG_EN];
    c.pwm_sel = c1[SFSC_CFG1_PWM_SEL];
    c.closed = c1[SFSC_CFG1_CLOSED];
    c.prescale = c1[SFSC_CFG1_PRESC_HI:SFSC_CFG1_PRESC_LO];
    c.invert = c1[SFSC_CFG1_INVERT];
    c.ppr4 = c1[SFSC_CFG1_PPR];
    c.alert_mask = c2[SFSC_CFG2_MASK];
    c.window = c2[SFSC_CFG2_WIN_HI:SFSC_CFG2_WIN_LO];
    c.startup = c2[SFSC_CFG2_START_HI:SFSC_CFG2_START_LO];
    return c;
  endfunction : sfsc_decode_cfg

  // Distance between two counts
  function automatic logic [7:0] sfsc_abs_diff(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction : sfsc_abs_diff

endpackage : sfsc_pkg

// >>> rtl/sfsc_tach_meter.sv
`timescale 1ns/10ps
module sfsc_tach_meter
  import sfsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tach_pulse_in,
  input sfsc_cfg_t cfg,
  output sfsc_tach_t meas
);

  localparam sfsc_tach_state_t ST_RST = '{count: SFSC_MEASURED_RST, default: '0};

  sfsc_tach_state_t s_reg; // Registered state
  sfsc_tach_state_t s_next; // Next state
  logic [2:0] presc_mask; // Prescaler wrap mask
  logic [3:0] edges_need; // Rising edges per window
  logic tick; // Prescaled counting tick
  logic rise; // Tach rising edge

  assign presc_mask = 3'((4'h1 << cfg.prescale) - 4'h1);
  assign tick = (s_reg.presc & presc_mask) == presc_mask;
  // edges per window; codes 2 and 3 both take four times the code 0 edges
  assign edges_need = 4'((cfg.ppr4 ? 4'h2 : 4'h1) << ((cfg.window > 2'h2) ? 2'h2 : cfg.window));
  assign rise = tach_pulse_in & ~s_reg.tach_q;

  // Period counter; counts saturate so a stalled fan reads FFh
  always_comb begin
    s_next = s_reg;
    s_next.valid = 1'b0;
    s_next.transition = tach_pulse_in ^ s_reg.tach_q;
    s_next.tach_q = tach_pulse_in;
    s_next.presc = 3'(s_reg.presc + 3'h1);
    if (tick && s_reg.ticks != 8'hFF) begin
      s_next.ticks = 8'(s_reg.ticks + 8'h1);
    end
    if (rise) begin
      if (4'(s_reg.edges + 4'h1) >= edges_need) begin
        s_next.count = s_reg.ticks;
        s_next.ticks = 8'h00;
        s_next.edges = 4'h0;
        s_next.valid = 1'b1;
      end else begin
        s_next.edges = 4'(s_reg.edges + 4'h1);
      end
    end else if (s_reg.ticks == 8'hFF) begin
      // Too slow to measure
      s_next.count = 8'hFF;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= ST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign meas = '{valid: s_reg.valid, transition: s_reg.transition, count: s_reg.count};

  sat_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_reg.ticks == 8'hFF && !rise) |=> (s_reg.count == 8'hFF))
    else $error("Count did not saturate");

endmodule : sfsc_tach_meter

// >>> rtl/sfsc_top.sv
`timescale 1ns/10ps
module sfsc_top
  import sfsc_pkg::*;
#(
  parameter int unsigned STALL_CYCLES = 32'(SFSC_STALL_CYCLES),
  parameter int unsigned OOC_CYCLES = 32'(SFSC_OOC_CYCLES)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_strap_high,
  input wire logic address_strap_low,
  input wire logic tach_pulse_in,
  output logic fan_drive_out,
  output logic [8:0] fan_dac_level,
  output logic alert_out,
  output logic alert_oe
);

  localparam sfsc_top_state_t ST_RST = '{
    bus: SFSC_BUS_IDLE,
    scl_q: 1'b1,
    sda_q: 1'b1,
    own_addr: SFSC_ADDR_STRAP_FLOAT,
    target: SFSC_TARGET_RST,
    level: SFSC_LEVEL_RST,
    cfg1: SFSC_CFG1_RST,
    cfg2: SFSC_CFG2_RST,
    fail: SFSC_FLAGS_RST[SFSC_FLAG_FAIL],
    ooc_n: SFSC_FLAGS_RST[SFSC_FLAG_OOC_N],
    default: '0
  };

  sfsc_top_state_t s; // Registered state
  sfsc_top_state_t n; // Next state
  sfsc_cfg_t cfg; // Decoded configuration
  sfsc_tach_t meas; // Tach measurement
  logic scl_rise; // Clock line rising
  logic scl_fall; // Clock line falling
  logic bus_start; // Start or repeated start
  logic bus_stop; // Stop condition
  logic addr_hit; // Own address received
  logic ara_hit; // Alert response read while alert pending
  logic wr_commit; // Data byte lands in a register
  logic ara_clear; // Alert response byte loaded
  logic drive_off; // Fan commanded off
  logic reg_err; // Speed off by more than a quarter
  logic [7:0] startup_code; // Selected start-up drive code
  logic [8:0] duty; // Drive value actually applied
  logic [7:0] rd_byte; // Read data for the current command

  assign cfg = sfsc_decode_cfg(s.cfg1, s.cfg2);

  // Bus line events; pins are synchronous to core_clk
  assign scl_rise = scl_in & ~s.scl_q;
  assign scl_fall = ~scl_in & s.scl_q;
  assign bus_start = s.scl_q & scl_in & s.sda_q & ~sda_in;
  assign bus_stop = s.scl_q & scl_in & ~s.sda_q & sda_in;
  assign addr_hit = s.shift[7:1] == s.own_addr;
  assign ara_hit = (s.shift[7:1] == SFSC_ADDR_ALERT_RESP) & s.shift[0] & s.alert;
  assign wr_commit = scl_fall & ~bus_start & ~bus_stop & (s.bus == SFSC_BUS_WDATA) & (s.bit_cnt == 4'h8);
  assign ara_clear = scl_fall & ~bus_start & ~bus_stop & (s.bus == SFSC_BUS_RDATA) & (s.bit_cnt == 4'h9) & s.ara;

  // Fan is off when the setpoint asks for it in the active mode
  assign drive_off = cfg.closed ? (s.target == 8'hFF) : (s.level == 8'h00);
  assign reg_err = sfsc_abs_diff(meas.count, s.target) > (s.target >> 2);
  // start-up code is step times select
  assign startup_code = 8'({6'h00, cfg.startup} << SFSC_STARTUP_SHIFT);
  // closed loop uses 512 steps, open loop the level
  assign duty = cfg.closed ? s.drive : {s.level, 1'b0};

  // Register read mux; unused bits read zero
  always_comb begin
    unique case (s.cmd)
      SFSC_CMD_TARGET: rd_byte = s.target;
      SFSC_CMD_MEASURED: rd_byte = meas.count;
      SFSC_CMD_FLAGS: rd_byte = {6'h00, s.fail, s.ooc_n};
      SFSC_CMD_LEVEL: rd_byte = s.level;
      SFSC_CMD_CFG1: rd_byte = s.cfg1;
      SFSC_CMD_CFG2: rd_byte = {3'h0, s.cfg2};
      default: rd_byte = 8'h00;
    endcase
  end

  // Tach period measurement
  sfsc_tach_meter sfsc_tach_meter_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tach_pulse_in(tach_pulse_in),
    .cfg(cfg),
    .meas(meas)
  );

  // Next-state logic for bus engine, registers and fan control
  always_comb begin
    n = s;
    n.scl_q = scl_in;
    n.sda_q = sda_in;

    // catch strap once after reset release
    if (!s.strap_done) begin
      n.strap_done = 1'b1;
      n.own_addr = address_strap_high ? SFSC_ADDR_STRAP_HIGH :
                   address_strap_low ? SFSC_ADDR_STRAP_LOW : SFSC_ADDR_STRAP_FLOAT;
    end

    // byte transactions framed by start and stop
    if (bus_start) begin
      // Repeated start keeps the command pointer
      n.bus = SFSC_BUS_ADDR;
      n.bit_cnt = 4'h0;
      n.sda_drive = 1'b0;
      n.ara = 1'b0;
    end else if (bus_stop) begin
      n.bus = SFSC_BUS_IDLE;
      n.sda_drive = 1'b0;
    end else if (s.bus != SFSC_BUS_IDLE && s.bus != SFSC_BUS_IGNORE) begin
      if (scl_rise) begin
        if (s.bit_cnt < 4'h8) begin
          // Data bit; read bytes are shifted out on the fall instead
          if (s.bus != SFSC_BUS_RDATA) begin
            n.shift = {s.shift[6:0], sda_in};
          end
          n.bit_cnt = 4'(s.bit_cnt + 4'h1);
        end else if (s.bit_cnt == 4'h9 && s.bus == SFSC_BUS_RDATA && sda_in) begin
          // Master not-acknowledge ends the read
          n.bus = SFSC_BUS_IGNORE;
        end
      end else if (scl_fall) begin
        if (s.bit_cnt == 4'h8) begin
          // Byte complete: decide on acknowledge
          n.bit_cnt = 4'h9;
          n.sda_drive = 1'b1;
          unique case (s.bus)
            SFSC_BUS_ADDR: begin
              if (addr_hit) begin
                n.bus = s.shift[0] ? SFSC_BUS_RDATA : SFSC_BUS_CMD;
              end else if (ara_hit) begin
                n.bus = SFSC_BUS_RDATA;
                n.ara = 1'b1;
              end else begin
                // Other devices' traffic: stay silent until the next start or stop
                n.bus = SFSC_BUS_IGNORE;
                n.sda_drive = 1'b0;
              end
            end
            SFSC_BUS_CMD: begin
              n.cmd = s.shift;
              n.bus = SFSC_BUS_WDATA;
            end
            SFSC_BUS_WDATA: begin
              // read-only and unused bits keep state
              unique case (s.cmd)
                SFSC_CMD_TARGET: n.target = s.shift;
                SFSC_CMD_LEVEL: n.level = s.shift;
                SFSC_CMD_CFG1: n.cfg1 = s.shift;
                SFSC_CMD_CFG2: n.cfg2 = s.shift[4:0];
                default: n.cmd = s.cmd;
              endcase
            end
            default: begin
              // Read byte sent: release for the master's answer
              n.sda_drive = 1'b0;
            end
          endcase
        end else if (s.bit_cnt == 4'h9) begin
          // Acknowledge slot over
          n.bit_cnt = 4'h0;
          n.sda_drive = 1'b0;
          if (s.bus == SFSC_BUS_RDATA) begin
            n.shift = s.ara ? {s.own_addr, 1'b1} : rd_byte;
            n.sda_drive = s.ara ? ~s.own_addr[6] : ~rd_byte[7];
          end
        end else if (s.bus == SFSC_BUS_RDATA && s.bit_cnt != 4'h0) begin
          // Next read bit, most significant first
          n.shift = {s.shift[6:0], 1'b0};
          n.sda_drive = ~s.shift[6];
        end
      end
    end

    if (meas.transition || !cfg.stall_en || drive_off) begin
      n.stall_cnt = 32'h0;
    end else if (s.stall_cnt < STALL_CYCLES) begin
      n.stall_cnt = 32'(s.stall_cnt + 32'h1);
    end
    n.fail = cfg.stall_en & ~drive_off & (s.stall_cnt >= STALL_CYCLES);

    // Regulation watchdog, closed loop only
    if (cfg.reg_en && cfg.closed && !drive_off && reg_err) begin
      if (s.ooc_cnt < OOC_CYCLES) begin
        n.ooc_cnt = 32'(s.ooc_cnt + 32'h1);
      end
    end else begin
      n.ooc_cnt = 32'h0;
    end
    n.ooc_n = ~(cfg.reg_en & (s.ooc_cnt >= OOC_CYCLES));

    // latch on status change; set wins over the clear
    if (ara_clear) begin
      n.alert = 1'b0;
    end
    // mask keeps changes off the pin
    if (((n.fail != s.fail) || (n.ooc_n != s.ooc_n)) && !cfg.alert_mask) begin
      n.alert = 1'b1;
    end

    // closed loop steers drive toward the target
    if (!cfg.closed || s.target == 8'hFF) begin
      // Restart from the start-up code when the loop resumes
      n.drive = 9'h000;
    end else if (meas.valid) begin
      if (s.drive < {startup_code, 1'b0}) begin
        n.drive = {startup_code, 1'b0};
      end else if ({1'b0, meas.count} > 9'({1'b0, s.target} + 9'h001)) begin
        // Slow fan: long count, more drive
        if (s.drive != 9'h1FF) begin
          n.drive = 9'(s.drive + 9'h001);
        end
      end else if (9'({1'b0, meas.count} + 9'h001) < {1'b0, s.target}) begin
        if (s.drive != 9'h000) begin
          n.drive = 9'(s.drive - 9'h001);
        end
      end
    end

    n.pwm_cnt = 9'(s.pwm_cnt + 9'h001);
    n.pwm_q = cfg.pwm_sel & ((s.pwm_cnt < duty) ^ cfg.invert);
    n.dac = cfg.pwm_sel ? 9'h000 : duty;
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  // Open-drain pins only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = s.sda_drive;
  assign alert_out = 1'b0;
  assign alert_oe = s.alert;
  assign fan_drive_out = s.pwm_q;
  assign fan_dac_level = s.dac;

  // Address follows the strap level seen at release
  strap_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(s.strap_done) |-> s.own_addr == ($past(address_strap_high) ? SFSC_ADDR_STRAP_HIGH :
      $past(address_strap_low) ? SFSC_ADDR_STRAP_LOW : SFSC_ADDR_STRAP_FLOAT))
    else $error("Slave address does not follow strap");

  // Setpoint write lands next cycle
  target_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_commit && s.cmd == SFSC_CMD_TARGET) |=> s.target == $past(s.shift))
    else $error("Target write lost");

  // Status read shows both flags
  flag_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.cmd == SFSC_CMD_FLAGS) |-> rd_byte[7:2] == 6'h00 && rd_byte[SFSC_FLAG_FAIL] == s.fail &&
      rd_byte[SFSC_FLAG_OOC_N] == s.ooc_n)
    else $error("Status byte layout wrong");

  // Linear output follows open-loop level
  open_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cfg.closed && !cfg.pwm_sel) ##1 $stable(s.cfg1) |-> s.dac == {$past(s.level), 1'b0})
    else $error("Open-loop level not applied");

  // Disabled detectors never raise flags
  detect_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cfg.stall_en && !cfg.reg_en) [*2] |-> (s.fail == 1'b0 && s.ooc_n == 1'b1))
    else $error("Flag raised while detection disabled");

  // Linear mode keeps the PWM pin low
  drive_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$past(cfg.pwm_sel) |-> !fan_drive_out)
    else $error("PWM pin active in linear mode");

  // Stop setpoint forces zero drive
  stop_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg.closed && s.target == 8'hFF) |=> s.drive == 9'h000)
    else $error("Drive not zero at stop setpoint");

  // Fail flag needs the full quiet time
  fail_time_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(s.fail) |-> $past(s.stall_cnt) >= STALL_CYCLES && $past(cfg.stall_en))
    else $error("Fail flag raised early");

  // Alert holds until the response read
  alert_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.alert && !ara_clear) |=> s.alert)
    else $error("Alert dropped without response read");

  // Masked alert never rises
  alert_mask_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg.alert_mask |=> !$rose(s.alert))
    else $error("Alert rose while masked");

  // Writes to read-only commands change nothing
  ro_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_commit && (s.cmd == SFSC_CMD_MEASURED || s.cmd == SFSC_CMD_FLAGS)) |=>
      $stable(s.target) && $stable(s.level) && $stable(s.cfg1) && $stable(s.cfg2))
    else $error("Read-only write changed state");

  // Own address is acknowledged
  addr_ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (scl_fall && !bus_start && !bus_stop && s.bus == SFSC_BUS_ADDR && s.bit_cnt == 4'h8 && addr_hit)
      |=> sda_oe ##1 sda_oe)
    else $error("Own address not acknowledged");

  // Regulation flag needs the full out-of-range time
  ooc_time_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(s.ooc_n) |-> $past(s.ooc_cnt) >= OOC_CYCLES && $past(cfg.reg_en))
    else $error("Regulation flag raised early");

  // First closed-loop measurement jumps to the start-up drive
  startup_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg.closed && s.target != 8'hFF && meas.valid && s.drive < {startup_code, 1'b0})
      |=> s.drive == {$past(startup_code), 1'b0})
    else $error("Start-up drive not applied");

  write_seen_c: cover property (@(posedge core_clk) disable iff (!rst_n) wr_commit);
  ooc_seen_c: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(s.ooc_n));
  ara_seen_c: cover property (@(posedge core_clk) disable iff (!rst_n) ara_clear);
  fail_seen_c: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(s.fail));
  pwm_seen_c: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(fan_drive_out));

endmodule : sfsc_top

// >>> testbench/sfsc_host_model.sv
`timescale 1ns/10ps
// SMBus host; sda is open drain, the wire has a pull-up
module sfsc_host_model
  import sfsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_pull
);
  // Bus idles high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Wait n clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // One bit; sda moves only while scl is low
  task automatic one_bit(input logic b, output logic r);
    sda_pull <= ~b;
    tick(3);
    scl <= 1'b1;
    tick(2);
    r = sda_in;
    tick(2);
    scl <= 1'b0;
    tick(3);
  endtask : one_bit
  // Start or repeated start
  task automatic start();
    sda_pull <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(3);
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b0;
    tick(3);
  endtask : start
  // Stop: sda rises while scl high
  task automatic stop();
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_pull <= 1'b0;
    tick(4);
  endtask : stop
  // Eight bits MSB first, then the ninth (ack) clock
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic nak);
    for (int i = 7; i >= 0; i--) one_bit(d[i], r[i]);
    one_bit(a, nak);
  endtask : xfer
  task automatic write_byte(input logic [6:0] ad, input logic [7:0] c, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic n0, n1, n2;
    start();
    xfer({ad, 1'b0}, 1'b1, r, n0);
    xfer(c, 1'b1, r, n1);
    xfer(d, 1'b1, r, n2);
    stop();
    ok = !(n0 | n1 | n2);
  endtask : write_byte
  // Read Byte format, ends with NACK
  task automatic read_byte(input logic [6:0] ad, input logic [7:0] c, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic n0, n1, n2, n3;
    start();
    xfer({ad, 1'b0}, 1'b1, r, n0);
    xfer(c, 1'b1, r, n1);
    start();
    xfer({ad, 1'b1}, 1'b1, r, n2);
    xfer(8'hFF, 1'b1, d, n3);
    stop();
    ok = !(n0 | n1 | n2);
  endtask : read_byte
  // Alert response read clears the latch
  task automatic ara_read(output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic n0, n1;
    start();
    xfer({SFSC_ADDR_ALERT_RESP, 1'b1}, 1'b1, r, n0);
    xfer(8'hFF, 1'b1, d, n1);
    stop();
    ok = !n0;
  endtask : ara_read
endmodule : sfsc_host_model

// >>> testbench/smbus_fan_speed_controller_bench.sv
`timescale 1ns/10ps
module smbus_fan_speed_controller_bench;
  import sfsc_pkg::*;
  localparam int unsigned STALL = 200;
  logic core_clk = 1'b0, rst_n = 1'b0, tach = 1'b0, strap_hi = 1'b0, strap_lo = 1'b0;
  logic scl, sda_pull, sda_out, sda_oe, fan_drive_out, alert_out, alert_oe, ok, ppr;
  logic [8:0] fan_dac_level;
  logic [7:0] d, v, lvl;
  logic [6:0] addr;
  logic [6:0] straps [3] = '{7'h3E, 7'h48, 7'h49};
  logic [7:0] rst_vals [6] = '{8'hFF, 8'hFF, 8'h01, 8'h00, 8'h10, 8'h01};
  int errors = 0, checks_done = 0, seed = 36, tach_half = 0, tcnt = 0, hi, w;
  // Wired-AND with pull-up
  wire sda_line = ~(sda_pull | (sda_oe & ~sda_out));
  wire alert_line = ~(alert_oe & ~alert_out);
  sfsc_top #(.STALL_CYCLES(STALL), .OOC_CYCLES(300)) sfsc_top_inst (.core_clk(core_clk), .rst_n(rst_n),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_high(strap_hi),
    .address_strap_low(strap_lo), .tach_pulse_in(tach), .fan_drive_out(fan_drive_out),
    .fan_dac_level(fan_dac_level), .alert_out(alert_out), .alert_oe(alert_oe));
  sfsc_host_model sfsc_host_model_inst (.core_clk(core_clk), .sda_in(sda_line), .scl(scl), .sda_pull(sda_pull));
  // 4 ns clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // Tach square wave, period 2*tach_half; zero stops it
  always @(posedge core_clk) begin
    if (tach_half != 0) begin
      tcnt <= (tcnt + 1 >= tach_half) ? 0 : tcnt + 1;
      if (tcnt + 1 >= tach_half) tach <= ~tach;
    end
  end
  // Verdict and end of run
  task automatic final_report();
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic check(input logic c, input string m);
    checks_done++;
    if (c !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : check
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : do_reset
  task automatic wr(input logic [7:0] c, input logic [7:0] x);
    sfsc_host_model_inst.write_byte(addr, c, x, ok);
    check(ok === 1'b1, "write not acknowledged");
  endtask : wr
  task automatic rd_chk(input logic [7:0] c, input logic [7:0] e, input string m);
    sfsc_host_model_inst.read_byte(addr, c, d, ok);
    check(ok === 1'b1 && d === e, m);
  endtask : rd_chk
  // Read-back per command after writing x
  function automatic logic [7:0] exp_rw(input int k, input logic [7:0] x);
    case (k)
      1: return 8'hFF;
      2: return 8'h01;
      5: return x & 8'h1F;
      default: return x;
    endcase
  endfunction : exp_rw
  // Ticks over the window, prescaled, saturating
  function automatic logic [7:0] exp_count(input int per, input int p, input int win, input logic four);
    int n;
    n = ((per * (four ? 2 : 1)) << win) >> p;
    return (n > 255) ? 8'hFF : 8'(n);
  endfunction : exp_count
  // Watchdog against a hung bus
  initial begin
    #300000;
    errors++;
    final_report();
  end
  initial begin
    for (int s = 0; s < 3; s++) begin
      strap_hi <= (s == 0);
      strap_lo <= (s == 2);
      addr = straps[s];
      do_reset();
      for (int k = 0; k < 6; k++) rd_chk(8'(k), rst_vals[k], "reset value");
      sfsc_host_model_inst.read_byte(straps[(s + 1) % 3], SFSC_CMD_CFG1, d, ok);
      check(ok === 1'b0, "foreign address acknowledged");
    end
    repeat (3) begin
      v = 8'($random(seed)) & 8'h3F;
      for (int k = 0; k < 6; k++) wr(8'(k), v);
      for (int k = 0; k < 6; k++) rd_chk(8'(k), exp_rw(k, v), "read-back");
    end
    tach_half = 32;
    for (int p = 0; p < 4; p++) begin
      w = ($random(seed) & 3) % 3;
      ppr = 1'($random(seed) & 1);
      wr(SFSC_CMD_CFG1, {4'h0, 2'(p), 1'b0, ppr});
      wr(SFSC_CMD_CFG2, {4'h0, 2'(w), 2'b01});
      repeat (1200) @(posedge core_clk);
      sfsc_host_model_inst.read_byte(addr, SFSC_CMD_MEASURED, d, ok);
      v = exp_count(64, p, w, ppr);
      check(d === v || d === v + 8'h01 || d === v - 8'h01, "tach count");
    end
    lvl = 8'($random(seed)) | 8'h01;
    wr(SFSC_CMD_LEVEL, lvl);
    for (int inv = 0; inv < 2; inv++) begin
      wr(SFSC_CMD_CFG1, {6'b001000, 1'(inv), 1'b0});
      repeat (600) @(posedge core_clk);
      hi = 0;
      repeat (512) begin
        @(posedge core_clk);
        hi += (fan_drive_out === 1'b1);
      end
      check(hi == (inv ? 512 - 2 * lvl : 2 * lvl) && fan_dac_level === 9'h000, "pwm duty");
    end
    wr(SFSC_CMD_CFG1, 8'h00);
    repeat (4) @(posedge core_clk);
    check(fan_drive_out === 1'b0 && fan_dac_level === {lvl, 1'b0}, "linear drive");
    // Stalled fan, detection off then on
    tach_half = 0;
    wr(SFSC_CMD_CFG2, 8'h01);
    repeat (STALL + 100) @(posedge core_clk);
    rd_chk(SFSC_CMD_FLAGS, 8'h01, "flag while disabled");
    check(alert_line === 1'b1, "alert without change");
    wr(SFSC_CMD_CFG1, 8'h80);
    repeat (STALL + 100) @(posedge core_clk);
    rd_chk(SFSC_CMD_FLAGS, 8'h03, "fail flag");
    check(alert_line === 1'b0, "alert not raised");
    sfsc_host_model_inst.ara_read(d, ok);
    check(ok === 1'b1 && d === {addr, 1'b1} && alert_line === 1'b1, "alert response");
    wr(SFSC_CMD_CFG2, 8'h10);
    tach_half = 32;
    repeat (400) @(posedge core_clk);
    rd_chk(SFSC_CMD_FLAGS, 8'h01, "fail cleared");
    check(alert_line === 1'b1, "masked alert raised");
    // Closed loop with a fan too slow for the target: drive climbs, regulation lost
    wr(SFSC_CMD_CFG2, 8'h01);
    wr(SFSC_CMD_TARGET, 8'h20);
    wr(SFSC_CMD_CFG1, 8'h50);
    repeat (1000) @(posedge core_clk);
    rd_chk(SFSC_CMD_FLAGS, 8'h00, "regulation not lost");
    check(fan_dac_level > 9'h040 && alert_line === 1'b0, "closed-loop drive");
    final_report();
  end
endmodule : smbus_fan_speed_controller_bench
